// >>> spb_map.svh
// Purpose: Offsets, field positions, reset values and timing of the switch
//          control and power budget register bank.
// Assumes: Byte addresses within a 4 KB configuration space.
// Notes:   Definitions only.
`ifndef SPB_MAP_SVH
`define SPB_MAP_SVH


`define SPB_OFF_BUDGET_SEL   12'h284
`define SPB_OFF_BUDGET_READ  12'h288
`define SPB_OFF_BUDGET_CAP   12'h28C
`define SPB_OFF_BUDGET_WORD0 12'h300
`define SPB_OFF_STATUS       12'h400
`define SPB_OFF_CONTROL      12'h404

`define SPB_CAP_SA_BIT       0
`define SPB_STS_MODE_LSB     0
`define SPB_STS_MODE_MSB     2
`define SPB_STS_CCDS_BIT     5
`define SPB_STS_CCUS_BIT     6
`define SPB_STS_MSMB_BIT     7
`define SPB_STS_REFCLK_BIT   8
`define SPB_STS_HOLD_BIT     9
`define SPB_CTL_FUND_BIT     0
`define SPB_CTL_HOT_BIT      1
`define SPB_CTL_HOLD_BIT     2
`define SPB_CTL_UNLOCK_BIT   3
`define SPB_CTL_BVUL_BIT     4
`define SPB_CTL_LDDIS_BIT    5
`define SPB_CTL_EESKIP_BIT   6

`define SPB_MODE_EEPROM      3'h1
`define SPB_SEL_LAST         8'h07
`define SPB_SEL_RST          8'h00
`define SPB_FLAG_RST         1'b0

`define SPB_TRIG_DELAY_NS    1000000
`define SPB_CLK_PERIOD_NS    4

`endif

// >>> spb_pkg.sv
// Purpose: Types shared by the switch control and power budget block.
// Assumes: Constants come from spb_map.svh.
// Notes:   One-hot codes for the reset trigger sequencer.
package spb_pkg;
    typedef logic [31:0] spb_word_t;
    typedef enum logic [2:0] {
        SPB_TRIG_IDLE = 3'b001,
        SPB_TRIG_WAIT = 3'b010,
        SPB_TRIG_FIRE = 3'b100
    } spb_trig_state_t;
endpackage : spb_pkg

// >>> spb_regs.sv
// Purpose: Switch status/control and power budget register bank.
// Assumes: Requests and reset-phase levels come from logic on clk; straps are pins.
// Notes:   One request per cycle, answered one cycle later.
`include "spb_map.svh"

module spb_regs
    import spb_pkg::*;
#(
    parameter int TRIG_DELAY_CYCLES = `SPB_TRIG_DELAY_NS / `SPB_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Configuration access
    input  wire logic        cfg_req,
    input  wire logic        cfg_we,
    input  wire logic        cfg_from_smbus,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ack,
    output logic             cfg_refused,
    output logic      [31:0] cfg_rdata,
    // Reset phases and link state
    input  wire logic        fund_reset_active,
    input  wire logic        hot_reset_active,
    input  wire logic        eeprom_init_active,
    input  wire logic        dl_down,
    // Strap pins
    input  wire logic [2:0]  mode_strap,
    input  wire logic        common_clock_downstream_strap,
    input  wire logic        common_clock_upstream_strap,
    input  wire logic        master_smbus_slow_strap,
    input  wire logic        refclk_mode_strap,
    input  wire logic        reset_hold_strap,
    // Reset controls and system allocated flag
    output logic             fundamental_reset_start,
    output logic             hot_reset_start,
    output logic             link_retrain_start,
    output logic             core_hold,
    output logic             eeprom_init_enable,
    output logic             system_allocated_flag
);
    localparam int CW = $clog2(TRIG_DELAY_CYCLES + 1);
    localparam logic [CW-1:0] LOAD_CNT = CW'(TRIG_DELAY_CYCLES - 1);

    logic [1:0]  rst_sync_q;
    logic        rst_core_n;
    logic [7:0]  strap_meta_q;
    logic [7:0]  strap_sync_q;
    logic [1:0]  load_cnt_q;
    logic        strap_capture;
    logic [2:0]  switch_operating_mode_q;
    logic [4:0]  strap_flags_q;
    logic        reset_hold_q;
    logic        lockable_write_enable_q;
    logic        budget_value_unlock_q;
    logic        linkdown_hotreset_disable_q;
    logic        hotreset_eeprom_skip_q;
    logic        system_allocated_q;
    logic [7:0]  budget_select_q;
    logic        accept;
    logic        wr;
    logic        wr_ctl;
    logic        wr_word;
    logic        word_hit;
    logic        read_hit;
    logic [2:0]  mem_raddr;
    spb_word_t   mem_rdata;
    spb_word_t   reg_rdata_q;
    spb_word_t   reg_rdata_d;
    logic        rd_mem_q;
    logic        rd_zero_q;
    logic        dl_down_q;
    logic        hot_link_q;
    spb_trig_state_t trig_q;
    logic [CW-1:0]   trig_cnt_q;
    logic        trig_fund_q;
    logic        fund_trig_wr;
    logic        hot_trig_wr;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_q[1];

    // Straps are asynchronous pins
    always_ff @(posedge clk) begin
        strap_meta_q <= {reset_hold_strap, refclk_mode_strap, master_smbus_slow_strap,
                         common_clock_upstream_strap, common_clock_downstream_strap,
                         mode_strap};
        strap_sync_q <= strap_meta_q;
    end

    // Synchroniser needs two edges after release before its output is valid
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            load_cnt_q <= 2'h0;
        end else if (load_cnt_q != 2'h3) begin
            load_cnt_q <= load_cnt_q + 2'h1;
        end
    end
    assign strap_capture = fund_reset_active || (load_cnt_q != 2'h3);

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            switch_operating_mode_q <= 3'h0;
            strap_flags_q           <= 5'h00;
        end else if (strap_capture) begin
            switch_operating_mode_q <= strap_sync_q[2:0];
            strap_flags_q           <= strap_sync_q[7:3];
        end
    end

    // Link-side requests are refused while the core is held
    assign accept  = cfg_req && (!core_hold || cfg_from_smbus);
    assign wr      = accept && cfg_we;
    assign wr_ctl  = wr && cfg_be[0] && (cfg_addr == `SPB_OFF_CONTROL);
    assign word_hit = (cfg_addr[11:5] == 7'(`SPB_OFF_BUDGET_WORD0 >> 5));
    assign wr_word = wr && word_hit && budget_value_unlock_q;
    assign read_hit = word_hit || (cfg_addr == `SPB_OFF_BUDGET_READ);
    assign fund_trig_wr = wr_ctl && cfg_wdata[`SPB_CTL_FUND_BIT];
    assign hot_trig_wr  = wr_ctl && cfg_wdata[`SPB_CTL_HOT_BIT];

    // Unlock is set by fundamental and hot resets; the set wins over a write
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            lockable_write_enable_q <= `SPB_FLAG_RST;
        end else if (fund_reset_active || hot_reset_active) begin
            lockable_write_enable_q <= 1'b1;
        end else if (wr_ctl) begin
            lockable_write_enable_q <= cfg_wdata[`SPB_CTL_UNLOCK_BIT];
        end
    end

    // Sticky fields: only a fundamental reset brings them back
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            budget_value_unlock_q       <= `SPB_FLAG_RST;
            linkdown_hotreset_disable_q <= `SPB_FLAG_RST;
            hotreset_eeprom_skip_q      <= `SPB_FLAG_RST;
        end else if (fund_reset_active) begin
            budget_value_unlock_q       <= `SPB_FLAG_RST;
            linkdown_hotreset_disable_q <= `SPB_FLAG_RST;
            hotreset_eeprom_skip_q      <= `SPB_FLAG_RST;
        end else if (wr_ctl) begin
            if (lockable_write_enable_q) begin
                budget_value_unlock_q <= cfg_wdata[`SPB_CTL_BVUL_BIT];
            end
            linkdown_hotreset_disable_q <= cfg_wdata[`SPB_CTL_LDDIS_BIT];
            hotreset_eeprom_skip_q      <= cfg_wdata[`SPB_CTL_EESKIP_BIT];
        end
    end

    // Hold bit stores any write, but only reset phases let it start a hold
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            reset_hold_q <= `SPB_FLAG_RST;
            core_hold    <= `SPB_FLAG_RST;
        end else if (strap_capture) begin
            reset_hold_q <= strap_sync_q[7];
            core_hold    <= strap_sync_q[7];
        end else begin
            if (wr_ctl) begin
                reset_hold_q <= cfg_wdata[`SPB_CTL_HOLD_BIT];
            end
            if (hot_reset_active) begin
                core_hold <= reset_hold_q;
            end else if (wr_ctl && eeprom_init_active) begin
                core_hold <= cfg_wdata[`SPB_CTL_HOLD_BIT];
            end else if (wr_ctl && !cfg_wdata[`SPB_CTL_HOLD_BIT]) begin
                core_hold <= 1'b0;
            end
        end
    end

    // Non-sticky fields: any reset clears them
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            system_allocated_q <= `SPB_FLAG_RST;
            budget_select_q    <= `SPB_SEL_RST;
        end else if (fund_reset_active || hot_reset_active) begin
            system_allocated_q <= `SPB_FLAG_RST;
            budget_select_q    <= `SPB_SEL_RST;
        end else begin
            if (wr && cfg_be[0] && cfg_addr == `SPB_OFF_BUDGET_CAP
                && lockable_write_enable_q) begin
                system_allocated_q <= cfg_wdata[`SPB_CAP_SA_BIT];
            end
            if (wr && cfg_be[0] && cfg_addr == `SPB_OFF_BUDGET_SEL) begin
                budget_select_q <= cfg_wdata[7:0];
            end
        end
    end
    assign system_allocated_flag = system_allocated_q;

    // Budget words: no reset, so they persist through both reset kinds
    assign mem_raddr = word_hit ? cfg_addr[4:2] : budget_select_q[2:0];

    spb_word_mem #(
        .WIDTH (32),
        .DEPTH (8),
        .AW    (3)
    ) u_words (
        .clk   (clk),
        .we    (wr_word),
        .waddr (cfg_addr[4:2]),
        .wbe   (cfg_be),
        .wdata (cfg_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // Register read data; reserved and unmapped bits are zero
    always_comb begin
        reg_rdata_d = '0;
        unique case (cfg_addr)
            `SPB_OFF_BUDGET_CAP: begin
                reg_rdata_d[`SPB_CAP_SA_BIT] = system_allocated_q;
            end
            `SPB_OFF_BUDGET_SEL: begin
                reg_rdata_d[7:0] = budget_select_q;
            end
            `SPB_OFF_STATUS: begin
                reg_rdata_d[`SPB_STS_MODE_MSB:`SPB_STS_MODE_LSB] = switch_operating_mode_q;
                reg_rdata_d[`SPB_STS_HOLD_BIT:`SPB_STS_CCDS_BIT] = strap_flags_q;
            end
            `SPB_OFF_CONTROL: begin
                reg_rdata_d[`SPB_CTL_HOLD_BIT]   = reset_hold_q;
                reg_rdata_d[`SPB_CTL_UNLOCK_BIT] = lockable_write_enable_q;
                reg_rdata_d[`SPB_CTL_BVUL_BIT]   = budget_value_unlock_q;
                reg_rdata_d[`SPB_CTL_LDDIS_BIT]  = linkdown_hotreset_disable_q;
                reg_rdata_d[`SPB_CTL_EESKIP_BIT] = hotreset_eeprom_skip_q;
            end
            default: begin
                reg_rdata_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            cfg_ack     <= 1'b0;
            cfg_refused <= 1'b0;
            reg_rdata_q <= '0;
            rd_mem_q    <= 1'b0;
            rd_zero_q   <= 1'b0;
        end else begin
            cfg_ack     <= cfg_req;
            cfg_refused <= cfg_req && !accept;
            reg_rdata_q <= (accept && !cfg_we) ? reg_rdata_d : '0;
            rd_mem_q    <= accept && !cfg_we && read_hit;
            rd_zero_q   <= !word_hit && (budget_select_q > `SPB_SEL_LAST);
        end
    end
    assign cfg_rdata = rd_mem_q ? (rd_zero_q ? '0 : mem_rdata) : reg_rdata_q;

    // Reset trigger sequencer: delay, then a one-cycle start pulse
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            trig_q      <= SPB_TRIG_IDLE;
            trig_cnt_q  <= '0;
            trig_fund_q <= 1'b0;
        end else if (fund_reset_active) begin
            trig_q <= SPB_TRIG_IDLE;
        end else begin
            unique case (trig_q)
                SPB_TRIG_IDLE: begin
                    if (fund_trig_wr || hot_trig_wr) begin
                        trig_q      <= SPB_TRIG_WAIT;
                        trig_cnt_q  <= LOAD_CNT;
                        trig_fund_q <= fund_trig_wr;
                    end
                end
                SPB_TRIG_WAIT: begin
                    if (fund_trig_wr) begin
                        trig_fund_q <= 1'b1;
                    end
                    if (trig_cnt_q == '0) begin
                        trig_q <= SPB_TRIG_FIRE;
                    end else begin
                        trig_cnt_q <= trig_cnt_q - CW'(1);
                    end
                end
                SPB_TRIG_FIRE: begin
                    trig_q <= SPB_TRIG_IDLE;
                end
            endcase
        end
    end

    // Link-down hot reset cause, suppressible
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            dl_down_q  <= 1'b0;
            hot_link_q <= 1'b0;
        end else begin
            dl_down_q  <= dl_down;
            hot_link_q <= dl_down && !dl_down_q && !linkdown_hotreset_disable_q;
        end
    end

    assign fundamental_reset_start = (trig_q == SPB_TRIG_FIRE) && trig_fund_q;
    assign link_retrain_start = (trig_q == SPB_TRIG_FIRE) && !trig_fund_q;
    assign hot_reset_start = link_retrain_start || hot_link_q;
    assign eeprom_init_enable = (switch_operating_mode_q == `SPB_MODE_EEPROM)
                                && !(hot_reset_active && hotreset_eeprom_skip_q);

    // Age since the trigger write, counted apart from the sequencer's own counter
    localparam logic [CW:0] AGE_FIRE = (CW + 1)'(TRIG_DELAY_CYCLES);
    logic [CW:0] trig_age_q;

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            trig_age_q <= '0;
        end else if (trig_q == SPB_TRIG_IDLE) begin
            trig_age_q <= '0;
        end else begin
            trig_age_q <= trig_age_q + {{CW{1'b0}}, 1'b1};
        end
    end

    // Checks
    sequence trig_write_s;
        !fund_reset_active && (fund_trig_wr || hot_trig_wr) && trig_q == SPB_TRIG_IDLE;
    endsequence

    trig_delay_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        fundamental_reset_start || link_retrain_start |-> trig_age_q == AGE_FIRE)
        else $error("reset started without the delay");
    trig_fire_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        trig_q == SPB_TRIG_WAIT && trig_cnt_q == '0 && !fund_reset_active
        |=> fundamental_reset_start || link_retrain_start)
        else $error("reset start missing after count");
    ack_first_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        trig_write_s |=> cfg_ack && trig_q == SPB_TRIG_WAIT)
        else $error("completion not ahead of reset");
    trig_zero_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        cfg_ack && $past(cfg_addr) == `SPB_OFF_CONTROL
        |-> cfg_rdata[`SPB_CTL_HOT_BIT:`SPB_CTL_FUND_BIT] == 2'h0)
        else $error("trigger bits read nonzero");
    lock_hold_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        !lockable_write_enable_q && !fund_reset_active && !hot_reset_active
        |=> $stable(budget_value_unlock_q) && $stable(system_allocated_q))
        else $error("lockable field changed while locked");
    unlock_set_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        hot_reset_active || fund_reset_active |=> lockable_write_enable_q)
        else $error("unlock not set by reset");
    sticky_hot_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        hot_reset_active && !fund_reset_active && !wr_ctl
        |=> $stable(linkdown_hotreset_disable_q) && $stable(hotreset_eeprom_skip_q))
        else $error("sticky option lost in hot reset");
    hold_late_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        !core_hold && !strap_capture && !hot_reset_active && !eeprom_init_active
        |=> !core_hold)
        else $error("hold restarted after reset");
    hold_refuse_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        cfg_req && core_hold && !cfg_from_smbus |=> cfg_refused && cfg_rdata == '0)
        else $error("link access served during hold");
    linkdown_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        $past(linkdown_hotreset_disable_q) && !link_retrain_start |-> !hot_reset_start)
        else $error("link-down hot reset not suppressed");
    sel_zero_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        accept && !cfg_we && cfg_addr == `SPB_OFF_BUDGET_READ
        && budget_select_q > `SPB_SEL_LAST |=> cfg_rdata == '0)
        else $error("out-of-range select read nonzero");
endmodule : spb_regs

// >>> spb_requester.sv
// Purpose: Configuration requester model facing the register bank.
// Assumes: One-cycle request, answer exactly one cycle later.
// Notes:   Write data is inverted after the request so a stale value never matches.
module spb_requester (
    // Clock
    input  wire logic        clk,
    // Request
    output logic             cfg_req,
    output logic             cfg_we,
    output logic             cfg_from_smbus,
    output logic [11:0]      cfg_addr,
    output logic [3:0]       cfg_be,
    output logic [31:0]      cfg_wdata,
    // Answer
    input  wire logic        cfg_ack,
    input  wire logic        cfg_refused,
    input  wire logic [31:0] cfg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cfg_req        = 1'b0;
        cfg_we         = 1'b0;
        cfg_from_smbus = 1'b0;
        cfg_addr       = 12'h000;
        cfg_be         = 4'hF;
        cfg_wdata      = 32'h0;
    end
    task automatic access(input logic we, input logic [11:0] addr, input logic [31:0] wdata,
                          input logic smb, output logic [31:0] rdata, output logic ok);
        @(posedge clk);
        #1;
        cfg_req   = 1'b1;
        cfg_from_smbus = smb;
        cfg_we    = we;
        cfg_addr  = addr;
        cfg_wdata = wdata;
        @(posedge clk);
        #1;
        cfg_req   = 1'b0;
        cfg_from_smbus = 1'b0;
        cfg_wdata = ~wdata;
        rdata     = cfg_rdata;
        ok        = (cfg_ack === 1'b1) && (cfg_refused === 1'b0);
    endtask : access
endmodule : spb_requester

// >>> spb_word_mem.sv
// Purpose: Small byte-writable word store for the budget data words.
// Assumes: One write and one read port on the core clock.
// Notes:   Read data registered; contents have no reset, so they survive any reset.
module spb_word_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // Clock
    input  wire logic               clk,
    // Write port
    input  wire logic               we,
    input  wire logic [AW-1:0]      waddr,
    input  wire logic [WIDTH/8-1:0] wbe,
    input  wire logic [WIDTH-1:0]   wdata,
    // Read port
    input  wire logic [AW-1:0]      raddr,
    output logic      [WIDTH-1:0]   rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // One process owns the array; per-lane processes would drive it from several places
    always_ff @(posedge clk) begin
        for (int b = 0; b < WIDTH / 8; b++) begin
            if (we && wbe[b]) begin
                mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule : spb_word_mem

// >>> switch_control_power_budget_regs_bench.sv
// Purpose: Self-checking bench for the switch control and power budget registers.
// Assumes: Straps held from time zero; trigger delay shortened to DELAY cycles.
// Notes:   Each scenario is its own task and judges its own results.
`include "spb_map.svh"
module switch_control_power_budget_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DELAY = 8;
    localparam logic [11:0] CTL = `SPB_OFF_CONTROL;
    logic clk, rst_n, cfg_req, cfg_we, cfg_from_smbus, cfg_ack, cfg_refused;
    logic [11:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic fund_reset_active, hot_reset_active, eeprom_init_active, dl_down;
    logic [2:0] mode_strap;
    logic ccds, ccus, msmb, refclk, hold_strap;
    logic fund_start, hot_start, retrain, core_hold, ee_enable, sa_flag;
    int errors, n_compared;

    spb_requester req (.clk(clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_from_smbus(cfg_from_smbus), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_refused(cfg_refused),
        .cfg_rdata(cfg_rdata));
    spb_regs #(.TRIG_DELAY_CYCLES(DELAY)) uut (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_from_smbus(cfg_from_smbus), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_refused(cfg_refused),
        .cfg_rdata(cfg_rdata), .fund_reset_active(fund_reset_active),
        .hot_reset_active(hot_reset_active), .eeprom_init_active(eeprom_init_active),
        .dl_down(dl_down), .mode_strap(mode_strap), .common_clock_downstream_strap(ccds),
        .common_clock_upstream_strap(ccus), .master_smbus_slow_strap(msmb),
        .refclk_mode_strap(refclk), .reset_hold_strap(hold_strap),
        .fundamental_reset_start(fund_start), .hot_reset_start(hot_start),
        .link_retrain_start(retrain), .core_hold(core_hold),
        .eeprom_init_enable(ee_enable), .system_allocated_flag(sa_flag));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic results();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        req.access(1'b0, a, 32'h0, 1'b0, d, ok);
        check("ack", 32'h1, {31'h0, ok});
        check($sformatf("read %h", a), exp, d);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic smb = 1'b0);
        logic [31:0] d;
        logic ok;
        req.access(1'b1, a, v, smb, d, ok);
        check("write ack", 32'h1, {31'h0, ok});
    endtask : wr
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic scen_reset();
        rd(`SPB_OFF_STATUS, 32'h0000_00A1);
        rd(CTL, 32'h0000_0008);
        rd(`SPB_OFF_BUDGET_CAP, 32'h0);
        check("ee enable", 32'h1, {31'h0, ee_enable});
    endtask : scen_reset
    task automatic scen_hold();
        logic [31:0] d;
        logic ok;
        eeprom_init_active = 1'b1;
        wr(CTL, 32'h0C);
        eeprom_init_active = 1'b0;
        check("core hold", 32'h1, {31'h0, core_hold});
        req.access(1'b0, CTL, 32'h0, 1'b0, d, ok);
        check("refused ack", 32'h0, {31'h0, ok});
        check("refused data", 32'h0, d);
        wr(CTL, 32'h08, 1'b1);
        check("hold released", 32'h0, {31'h0, core_hold});
        wr(CTL, 32'h0C);
        check("late hold", 32'h0, {31'h0, core_hold});
        wr(CTL, 32'h08);
    endtask : scen_hold
    task automatic scen_skip();
        wr(CTL, 32'h48);
        hot_reset_active = 1'b1;
        settle(2);
        check("ee skip", 32'h0, {31'h0, ee_enable});
        hot_reset_active = 1'b0;
        settle(2);
        check("ee enable", 32'h1, {31'h0, ee_enable});
        rd(CTL, 32'h48);
        wr(CTL, 32'h08);
    endtask : scen_skip
    task automatic scen_lock();
        wr(`SPB_OFF_BUDGET_CAP, 32'hFFFF_FFFF);
        rd(`SPB_OFF_BUDGET_CAP, 32'h1);
        check("sa flag", 32'h1, {31'h0, sa_flag});
        wr(CTL, 32'h18);
        rd(CTL, 32'h18);
        for (int i = 0; i < 8; i++) wr(`SPB_OFF_BUDGET_WORD0 + 12'(i * 4), 32'hC35A_0000 | i);
        for (int i = 0; i < 8; i++) begin
            rd(`SPB_OFF_BUDGET_WORD0 + 12'(i * 4), 32'hC35A_0000 | i);
        end
        wr(`SPB_OFF_BUDGET_SEL, 32'h3);
        rd(`SPB_OFF_BUDGET_READ, 32'hC35A_0003);
        wr(`SPB_OFF_BUDGET_SEL, 32'h8);
        rd(`SPB_OFF_BUDGET_READ, 32'h0);
        wr(CTL, 32'h00);
        wr(CTL, 32'h10);
        rd(CTL, 32'h0);
        wr(`SPB_OFF_BUDGET_CAP, 32'h0);
        rd(`SPB_OFF_BUDGET_CAP, 32'h1);
        wr(`SPB_OFF_BUDGET_WORD0, 32'hFFFF_FFFF);
        rd(`SPB_OFF_BUDGET_WORD0, 32'hC35A_0000);
    endtask : scen_lock
    task automatic scen_reserved();
        wr(CTL, 32'hFFFF_FF88);
        rd(CTL, 32'h08);
        wr(12'h500, 32'h1234_5678);
        rd(12'h500, 32'h0);
    endtask : scen_reserved
    task automatic scen_trigger(input int b);
        int seen, cnt, rcnt;
        logic s;
        wr(CTL, 32'h8 | (32'h1 << b));
        seen = -1;
        cnt = 0;
        rcnt = 0;
        for (int k = 0; k < DELAY + 4; k++) begin
            s = (b == 0) ? fund_start : hot_start;
            if (s === 1'b1) begin
                cnt++;
                if (seen < 0) seen = k;
            end
            if (retrain === 1'b1) rcnt++;
            settle(1);
        end
        check("trigger delay", DELAY, seen);
        check("start pulses", 32'h1, cnt);
        check("retrain pulses", b, rcnt);
        rd(CTL, 32'h08);
        wr(CTL, 32'h08);
        cnt = 0;
        for (int k = 0; k < DELAY + 4; k++) begin
            if (fund_start !== 1'b0 || hot_start !== 1'b0) cnt++;
            settle(1);
        end
        check("zero write", 32'h0, cnt);
    endtask : scen_trigger
    task automatic link_down(input int exp);
        int cnt;
        cnt = 0;
        dl_down = 1'b1;
        for (int k = 0; k < 4; k++) begin
            settle(1);
            if (hot_start === 1'b1) cnt++;
        end
        dl_down = 1'b0;
        settle(2);
        check("link down reset", exp, cnt);
    endtask : link_down

    initial begin
        errors = 0;
        n_compared = 0;
        rst_n = 1'b0;
        fund_reset_active = 1'b0;
        hot_reset_active = 1'b0;
        eeprom_init_active = 1'b0;
        dl_down = 1'b0;
        mode_strap = `SPB_MODE_EEPROM;
        {ccds, ccus, msmb, refclk, hold_strap} = 5'b10100;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        settle(4);
        fund_reset_active = 1'b1;
        settle(4);
        fund_reset_active = 1'b0;
        settle(2);
        scen_reset();
        scen_hold();
        scen_skip();
        scen_lock();
        scen_reserved();
        scen_trigger(0);
        scen_trigger(1);
        link_down(1);
        wr(CTL, 32'h28);
        link_down(0);
        results();
    end
endmodule : switch_control_power_budget_regs_bench
